// [rtl/link_cfg_defs.svh]
/*
 * shared constants for the serial link transport configuration pair:
 * register offsets, field positions, rate limits and band codes.
 * assumes both ends and the bench include it by bare name.
 */
// Overview of operation
// RULE1 - lane rate 1687.5..15500 Mbps, rate/40 <= converter rate
// RULE2 - lcm(20*ratio*out_rate/lane rate, ratio) at most 64
// RULE3 - above 13500 up to 15500 Mbps: band 0x30
// RULE4 - 6750 to 13500 Mbps: band 0x00
// RULE5 - 12-bit words, 3375 to 6750 Mbps: band 0x10
// RULE6 - 12-bit words, 1687.5 to 3375 Mbps: band 0x50
// RULE7 - 8-bit words, 1687.5 to 6750 Mbps: band 0x50
// RULE8 - K times F divisible by four, K per F
// RULE9 - output rate is converter rate over decimation
// RULE10 - 8-bit mode limits N, CS, lanes, converters
// RULE11 - decimation must be supported within the band
// RULE12 - lane rate scales with output rate per settings
// RULE13 - write band and settings before enabling link
`ifndef LINK_CFG_DEFS_SVH
`define LINK_CFG_DEFS_SVH

// device-side registers, 12-bit address, 8-bit data
`define DEV_BAND_ADDR      12'h56E
`define DEV_LANES_ADDR     12'h570
`define DEV_CONVS_ADDR     12'h571
`define DEV_OCTETS_ADDR    12'h572
`define DEV_FRAMES_ADDR    12'h573
`define DEV_RES_ADDR       12'h574
`define DEV_MODE_ADDR      12'h575
`define DEV_DECIM_ADDR     12'h576
`define DEV_ENABLE_ADDR    12'h577
`define DEV_STATUS_ADDR    12'h57F
`define DEV_MODE_CS_LSB    0
`define DEV_MODE_WIDE_BIT  2

// band codes
`define BAND_TOP           8'h30
`define BAND_HIGH          8'h00
`define BAND_MID           8'h10
`define BAND_LOW           8'h50

// rate limits in Mbps (minimum kept doubled to hold the half)
`define LANE_MIN_X2        32'd3375
`define LANE_MAX           32'd15500
`define LANE_TOP_LO        32'd13500
`define LANE_HIGH_LO       32'd6750
`define LANE_MID_LO        32'd3375
`define LANE_PER_CONV      32'd40
`define LCM_FACTOR         32'd20
`define LCM_MAX            32'd64

// controller registers on AXI4-Lite, byte addresses
`define REG_CTRL           6'h00
`define REG_LANE_RATE      6'h04
`define REG_CONV_RATE      6'h08
`define REG_DECIM          6'h0C
`define REG_LINK           6'h10
`define REG_STATUS         6'h14
`define CTRL_GO_BIT        0
`define LINK_L_LSB         0
`define LINK_M_LSB         4
`define LINK_F_LSB         8
`define LINK_K_LSB         16
`define LINK_N_LSB         24
`define LINK_CS_LSB        28
`define LINK_WIDE_BIT      30
`define ST_BUSY_BIT        0
`define ST_DONE_BIT        1
`define ST_RATE_ERR_BIT    2
`define ST_LCM_ERR_BIT     3
`define ST_DECIM_ERR_BIT   4
`define ST_BAND_LSB        8
`define AXI_OKAY           2'b00
`define AXI_SLVERR         2'b10

`endif

// [rtl/link_cfg_pkg.sv]
/*
 * types shared by the controller and the converter end.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package link_cfg_pkg;
    typedef enum {ST_IDLE, ST_CHECK, ST_GCD, ST_WRITE, ST_WAIT, ST_DONE} host_state_t;
    typedef logic [11:0] cfg_addr_t;
    typedef logic [7:0]  cfg_data_t;
endpackage : link_cfg_pkg

// [rtl/cfg_port_if.sv]
/*
 * configuration port between controller and converter end.
 * assumes one shared clock; the request holds until the one-cycle ack.
 */
interface cfg_port_if;
    import link_cfg_pkg::*;
    logic      req;
    logic      wr;
    cfg_addr_t addr;
    cfg_data_t wdata;
    logic      ack;
    cfg_data_t rdata;
    modport dev  (input req, input wr, input addr, input wdata, output ack, output rdata);
    modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface : cfg_port_if

// [rtl/link_cfg_device.sv]
/*
 * converter end: holds the band and link settings, judges them and
 * derives output and lane rates. assumes the controller keeps its
 * request steady until ack, on the same SYS_CLK.
 */
`include "link_cfg_defs.svh"
module link_cfg_device
    import link_cfg_pkg::*;
#(
    parameter int RATE_W = 16
)(
    input  wire logic              SYS_CLK,
    input  wire logic              RST_N,
    cfg_port_if.dev                CFG,
    input  wire logic [RATE_W-1:0] CONV_RATE_MSPS,
    output logic      [RATE_W-1:0] OUT_RATE_MSPS,
    output logic      [RATE_W-1:0] LANE_RATE_MBPS,
    output logic      [7:0]        BAND,
    output logic                   CFG_LEGAL,
    output logic                   LINK_ACTIVE
);
    if (RATE_W < 8 || RATE_W > 24) $error("RATE_W out of range");
    cfg_data_t band, lanes, convs, octets, frames, res, mode, decim, enable, rdata;
    cfg_data_t next_band, next_lanes, next_convs, next_octets, next_frames;
    cfg_data_t next_res, next_mode, next_decim, next_enable, next_rdata;
    logic      ack, next_ack;
    logic      kf_ok, mode_ok, legal, next_legal;
    logic [31:0] out_rate, lane_rate;
    // register writes and reads; ack is one cycle per request
    always_comb
    begin
        next_band = band;  next_lanes = lanes;   next_convs = convs;
        next_octets = octets; next_frames = frames; next_res = res;
        next_mode = mode;  next_decim = decim;   next_enable = enable;
        next_rdata = rdata;
        next_ack = CFG.req & ~ack;
        if (CFG.req && !ack && CFG.wr)
        begin
            case (CFG.addr)
                `DEV_BAND_ADDR:   next_band   = CFG.wdata;
                `DEV_LANES_ADDR:  next_lanes  = CFG.wdata;
                `DEV_CONVS_ADDR:  next_convs  = CFG.wdata;
                `DEV_OCTETS_ADDR: next_octets = CFG.wdata;
                `DEV_FRAMES_ADDR: next_frames = CFG.wdata;
                `DEV_RES_ADDR:    next_res    = CFG.wdata;
                `DEV_MODE_ADDR:   next_mode   = CFG.wdata;
                `DEV_DECIM_ADDR:  next_decim  = CFG.wdata;
                `DEV_ENABLE_ADDR: next_enable = CFG.wdata;
                default:          ; // unmapped writes vanish
            endcase
        end
        if (CFG.req && !ack && !CFG.wr)
        begin
            case (CFG.addr)
                `DEV_BAND_ADDR:   next_rdata = band;
                `DEV_LANES_ADDR:  next_rdata = lanes;
                `DEV_CONVS_ADDR:  next_rdata = convs;
                `DEV_OCTETS_ADDR: next_rdata = octets;
                `DEV_FRAMES_ADDR: next_rdata = frames;
                `DEV_RES_ADDR:    next_rdata = res;
                `DEV_MODE_ADDR:   next_rdata = mode;
                `DEV_DECIM_ADDR:  next_rdata = decim;
                `DEV_ENABLE_ADDR: next_rdata = enable;
                `DEV_STATUS_ADDR: next_rdata = {7'h00, legal};
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    // legality of the frame and word settings
    always_comb
    begin
        kf_ok = (frames[1:0] == 2'b00) && (frames <= 8'h20) && (frames != 8'h00); // [RULE8]
        case (octets)
            8'h01:   kf_ok = kf_ok && (frames >= 8'h14); // [RULE8]
            8'h02:   kf_ok = kf_ok && (frames >= 8'h0C); // [RULE8]
            8'h04:   kf_ok = kf_ok && (frames >= 8'h08); // [RULE8]
            8'h08,
            8'h10:   kf_ok = kf_ok && (frames >= 8'h04); // [RULE8]
            8'h03,
            8'h06:   kf_ok = kf_ok && mode[`DEV_MODE_WIDE_BIT]; // 12-bit rows only
            default: kf_ok = 1'b0;
        endcase
        if (!mode[`DEV_MODE_WIDE_BIT])
            mode_ok = (res == 8'h07 || res == 8'h08)                     // [RULE10]
                   && (mode[`DEV_MODE_CS_LSB+:2] <= 2'd1)                // [RULE10]
                   && (lanes == 8'h01 || lanes == 8'h02 || lanes == 8'h04) // [RULE10]
                   && (convs == 8'h01 || convs == 8'h02);                // [RULE10]
        else
            mode_ok = (res >= 8'h08) && (res <= 8'h0C)
                   && (lanes >= 8'h01) && (lanes <= 8'h04)
                   && (convs == 8'h01 || convs == 8'h02 || convs == 8'h04 || convs == 8'h08);
        next_legal = kf_ok && mode_ok && (decim != 8'h00);
    end

    // rate derivation; a zero ratio or lane count yields zero rather than a fault
    always_comb
    begin
        out_rate = (decim == 8'h00) ? 32'd0
                 : 32'(CONV_RATE_MSPS) / 32'(decim); // [RULE9]
        lane_rate = (lanes == 8'h00) ? 32'd0
                  : (out_rate * 32'(convs) * (mode[`DEV_MODE_WIDE_BIT] ? 32'd12 : 32'd8)
                     * 32'd10) / (32'd8 * 32'(lanes)); // [RULE12]
    end

    // state registers and registered outputs
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            band <= `BAND_HIGH; lanes <= 8'h01; convs <= 8'h01; octets <= 8'h01;
            frames <= 8'h20; res <= 8'h08; mode <= 8'h00; decim <= 8'h01;
            enable <= 8'h00; rdata <= 8'h00; ack <= 1'b0; legal <= 1'b0;
            OUT_RATE_MSPS <= '0; LANE_RATE_MBPS <= '0; BAND <= `BAND_HIGH;
            CFG_LEGAL <= 1'b0; LINK_ACTIVE <= 1'b0;
        end
        else
        begin
            band <= next_band; lanes <= next_lanes; convs <= next_convs;
            octets <= next_octets; frames <= next_frames; res <= next_res;
            mode <= next_mode; decim <= next_decim; enable <= next_enable;
            rdata <= next_rdata; ack <= next_ack; legal <= next_legal;
            OUT_RATE_MSPS <= out_rate[RATE_W-1:0];
            LANE_RATE_MBPS <= lane_rate[RATE_W-1:0];
            BAND <= band;
            CFG_LEGAL <= legal;
            LINK_ACTIVE <= legal && enable[0]; // illegal settings keep link down
        end
    end

    assign CFG.ack   = ack;
    assign CFG.rdata = rdata;
endmodule : link_cfg_device

// [rtl/link_cfg_host.sv]
/*
 * controller end: AXI4-Lite registers take the wanted rates and link
 * settings, the constraints are checked, the band is chosen and the
 * whole set is written to the converter, enable last, if no check fails.
 * assumes the converter answers each request with a one-cycle ack.
 */
`include "link_cfg_defs.svh"
module link_cfg_host
    import link_cfg_pkg::*;
#(
    parameter int RATE_W = 16
)(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    cfg_port_if.host         CFG,
    input  wire logic [5:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [5:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);
    if (RATE_W < 8 || RATE_W > 24) $error("RATE_W out of range");

    localparam logic [3:0] LAST_WRITE = 4'd8;

    // bus slave state
    logic        aw_full, w_full, next_aw_full, next_w_full;
    logic [5:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata, wr_merged;
    logic        fire;
    // software registers
    logic [31:0] lane_rate, conv_rate, link, next_lane_rate, next_conv_rate, next_link;
    logic [7:0]  decim, next_decim;
    logic        go;
    // sequencer state
    host_state_t state, next_state;
    logic [3:0]  idx, next_idx;
    logic [31:0] ga, gb, next_ga, next_gb;
    logic        busy, done, rate_err, lcm_err, decim_err;
    logic        next_done, next_rate_err, next_lcm_err, next_decim_err;
    logic [7:0]  band, next_band;
    logic        req, next_req;
    cfg_addr_t   addr, next_addr;
    cfg_data_t   wdat, next_wdat;
    logic [31:0] num, ratio, ratio_rem, lane_x2, lcm;
    logic [31:0] status;

    // merge byte strobes onto the register being written
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                res[b*8+:8] = nw[b*8+:8];
        return res;
    endfunction : merge

    // decimation ratios supported within each band; finer per-row limits are software's
    function automatic logic decim_allowed(input logic [7:0] d, input logic [7:0] bnd);
        logic listed;
        logic [7:0] cap;
        listed = (d >= 8'h01 && d <= 8'h06) || d == 8'h08 || d == 8'h0A || d == 8'h0C
              || d == 8'h0F || d == 8'h10 || d == 8'h14 || d == 8'h18 || d == 8'h1E
              || d == 8'h30;
        case (bnd)
            `BAND_TOP:  cap = 8'h04;
            `BAND_HIGH: cap = 8'h18;
            `BAND_MID:  cap = 8'h30;
            default:    cap = 8'h30;
        endcase
        return listed && (d <= cap);
    endfunction : decim_allowed

    assign status = {16'h0000, band, 3'b000, decim_err, lcm_err, rate_err, done, busy};
    assign fire   = aw_full && w_full && !BVALID;
    assign wr_merged = merge(32'h0, w_data, w_strb);

    // AXI4-Lite channels: address and data taken in either order, one write at a time
    always_comb
    begin
        next_aw_full = aw_full; next_aw_addr = aw_addr;
        next_w_full  = w_full;  next_w_data  = w_data; next_w_strb = w_strb;
        next_bvalid  = BVALID && !BREADY;
        next_bresp   = BRESP;
        if (AWVALID && AWREADY)
        begin
            next_aw_full = 1'b1;
            next_aw_addr = AWADDR;
        end
        if (WVALID && WREADY)
        begin
            next_w_full = 1'b1;
            next_w_data = WDATA;
            next_w_strb = WSTRB;
        end
        if (fire)
        begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (aw_addr > `REG_LINK || aw_addr[1:0] != 2'b00) ? `AXI_SLVERR
                                                                           : `AXI_OKAY;
        end
        next_awready = !next_aw_full;
        next_wready  = !next_w_full;
        next_rvalid  = RVALID && !RREADY;
        next_rdata   = RDATA;
        next_rresp   = RRESP;
        if (ARVALID && ARREADY)
        begin
            next_rvalid = 1'b1;
            next_rresp  = `AXI_OKAY;
            case (ARADDR)
                `REG_CTRL:      next_rdata = {31'h0, busy};
                `REG_LANE_RATE: next_rdata = lane_rate;
                `REG_CONV_RATE: next_rdata = conv_rate;
                `REG_DECIM:     next_rdata = {24'h0, decim};
                `REG_LINK:      next_rdata = link;
                `REG_STATUS:    next_rdata = status;
                default:
                begin
                    next_rdata = 32'h0;
                    next_rresp = `AXI_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    // software registers; a go while busy is ignored
    always_comb
    begin
        next_lane_rate = lane_rate; next_conv_rate = conv_rate;
        next_link = link; next_decim = decim; go = 1'b0;
        if (fire)
        begin
            case (aw_addr)
                `REG_CTRL:      go = wr_merged[`CTRL_GO_BIT] && !busy;
                `REG_LANE_RATE: next_lane_rate = merge(lane_rate, w_data, w_strb);
                `REG_CONV_RATE: next_conv_rate = merge(conv_rate, w_data, w_strb);
                `REG_DECIM:     next_decim = 8'(merge({24'h0, decim}, w_data, w_strb));
                `REG_LINK:      next_link = merge(link, w_data, w_strb);
                default:        ;
            endcase
        end
    end

    // constraint arithmetic from the programmed rates
    always_comb
    begin
        lane_x2   = {lane_rate[30:0], 1'b0};
        num       = `LCM_FACTOR * conv_rate; // ratio*out_rate equals converter rate
        ratio     = (lane_rate == 32'd0) ? 32'd0 : num / lane_rate;
        ratio_rem = (lane_rate == 32'd0) ? 32'd1 : num % lane_rate;
        lcm       = (ga == 32'd0) ? 32'hFFFF_FFFF : (ratio * 32'(decim)) / ga;
    end

    // sequencer: check, gcd by subtraction, then write the set in order
    always_comb
    begin
        next_state = state; next_idx = idx; next_ga = ga; next_gb = gb;
        next_done = done; next_rate_err = rate_err; next_lcm_err = lcm_err;
        next_decim_err = decim_err; next_band = band;
        next_req = req; next_addr = addr; next_wdat = wdat;
        case (state)
            ST_IDLE:
                if (go)
                begin
                    next_done = 1'b0;
                    next_state = ST_CHECK;
                end
            ST_CHECK:
            begin
                if (lane_rate > `LANE_TOP_LO)        next_band = `BAND_TOP;  // [RULE3]
                else if (lane_rate >= `LANE_HIGH_LO) next_band = `BAND_HIGH; // [RULE4]
                else if (link[`LINK_WIDE_BIT] && lane_rate >= `LANE_MID_LO)
                                                     next_band = `BAND_MID;  // [RULE5]
                else if (link[`LINK_WIDE_BIT])       next_band = `BAND_LOW;  // [RULE6]
                else                                 next_band = `BAND_LOW;  // [RULE7]
                next_rate_err = (lane_x2 < `LANE_MIN_X2) || (lane_rate > `LANE_MAX) // [RULE1]
                             || (lane_rate > `LANE_PER_CONV * conv_rate);           // [RULE1]
                next_lcm_err = (ratio_rem != 32'd0) || (ratio == 32'd0)
                            || (ratio > `LCM_MAX) || (decim == 8'h00);              // [RULE2]
                next_ga = ratio;
                next_gb = {24'h0, decim};
                next_state = ST_GCD;
            end
            ST_GCD:
                if (lcm_err || ga == gb || ga == 32'd0 || gb == 32'd0)
                begin
                    next_lcm_err = lcm_err || (lcm > `LCM_MAX);                     // [RULE2]
                    next_decim_err = !decim_allowed(decim, band);                   // [RULE11]
                    next_idx = 4'd0;
                    next_state = ST_WRITE;
                end
                else if (ga > gb)
                    next_ga = ga - gb;
                else
                    next_gb = gb - ga;
            ST_WRITE:
                if (rate_err || lcm_err || decim_err)
                begin
                    next_done = 1'b1;  // refuse to program a set that breaks a limit
                    next_state = ST_IDLE;
                end
                else
                begin
                    next_req = 1'b1;
                    next_state = ST_WAIT;
                    case (idx) // band and settings go before enable
                        4'd0: begin next_addr = `DEV_BAND_ADDR;   next_wdat = band;           end // [RULE13]
                        4'd1: begin next_addr = `DEV_LANES_ADDR;  next_wdat = {5'h0, link[`LINK_L_LSB+:3]}; end
                        4'd2: begin next_addr = `DEV_CONVS_ADDR;  next_wdat = {4'h0, link[`LINK_M_LSB+:4]}; end
                        4'd3: begin next_addr = `DEV_OCTETS_ADDR; next_wdat = {3'h0, link[`LINK_F_LSB+:5]}; end
                        4'd4: begin next_addr = `DEV_FRAMES_ADDR; next_wdat = {2'h0, link[`LINK_K_LSB+:6]}; end
                        4'd5: begin next_addr = `DEV_RES_ADDR;    next_wdat = {4'h0, link[`LINK_N_LSB+:4]}; end
                        4'd6: begin next_addr = `DEV_MODE_ADDR;
                                    next_wdat = {5'h0, link[`LINK_WIDE_BIT], link[`LINK_CS_LSB+:2]}; end
                        4'd7: begin next_addr = `DEV_DECIM_ADDR;  next_wdat = decim;          end
                        default: begin next_addr = `DEV_ENABLE_ADDR; next_wdat = 8'h01;     end // [RULE13]
                    endcase
                end
            ST_WAIT:
                if (CFG.ack)
                begin
                    next_req = 1'b0;
                    next_idx = idx + 4'd1;
                    next_state = (idx == LAST_WRITE) ? ST_DONE : ST_WRITE;
                end
            ST_DONE:
            begin
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    assign busy = (state != ST_IDLE);

    // all registers of the controller
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            aw_full <= 1'b0; w_full <= 1'b0; aw_addr <= 6'h00; w_data <= 32'h0;
            w_strb <= 4'h0; AWREADY <= 1'b0; WREADY <= 1'b0; BVALID <= 1'b0;
            BRESP <= `AXI_OKAY; ARREADY <= 1'b0; RVALID <= 1'b0; RDATA <= 32'h0;
            RRESP <= `AXI_OKAY; lane_rate <= 32'h0; conv_rate <= 32'h0;
            link <= 32'h0; decim <= 8'h01; state <= ST_IDLE; idx <= 4'd0;
            ga <= 32'h0; gb <= 32'h0; done <= 1'b0; rate_err <= 1'b0;
            lcm_err <= 1'b0; decim_err <= 1'b0; band <= `BAND_HIGH;
            req <= 1'b0; addr <= 12'h000; wdat <= 8'h00;
        end
        else
        begin
            aw_full <= next_aw_full; w_full <= next_w_full; aw_addr <= next_aw_addr;
            w_data <= next_w_data; w_strb <= next_w_strb; AWREADY <= next_awready;
            WREADY <= next_wready; BVALID <= next_bvalid; BRESP <= next_bresp;
            ARREADY <= next_arready; RVALID <= next_rvalid; RDATA <= next_rdata;
            RRESP <= next_rresp; lane_rate <= next_lane_rate; conv_rate <= next_conv_rate;
            link <= next_link; decim <= next_decim; state <= next_state; idx <= next_idx;
            ga <= next_ga; gb <= next_gb; done <= next_done; rate_err <= next_rate_err;
            lcm_err <= next_lcm_err; decim_err <= next_decim_err; band <= next_band;
            req <= next_req; addr <= next_addr; wdat <= next_wdat;
        end
    end

    assign CFG.req   = req;
    assign CFG.wr    = 1'b1;
    assign CFG.addr  = addr;
    assign CFG.wdata = wdat;
endmodule : link_cfg_host

// [tb/cfg_port_sva.sv]
/* port checks between both ends; assumes one clock and signals wired by name. */
`include "link_cfg_defs.svh"
module cfg_port_sva
    import link_cfg_pkg::*;
(
    input wire logic      SYS_CLK,
    input wire logic      RST_N,
    input wire logic      req,
    input wire logic      wr,
    input wire cfg_addr_t addr,
    input wire cfg_data_t wdata,
    input wire logic      ack,
    input wire cfg_data_t rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // handshake: held request, single answer, then release
    a_ack_next: assert property (req && !ack |=> ack) else $error("ack missing");
    a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
    a_req_held: assert property (req && !ack
        |=> req && $stable(addr) && $stable(wdata)) else $error("request moved");
    a_write_only: assert property (req |-> wr) else $error("host read");
    // only the band, the link settings and enable are ever written
    a_addr_map: assert property (req |-> addr == `DEV_BAND_ADDR
        || addr inside {[`DEV_LANES_ADDR:`DEV_ENABLE_ADDR]}) else $error("bad addr");
    a_band_code: assert property (req && addr == `DEV_BAND_ADDR |-> wdata inside
        {`BAND_TOP, `BAND_HIGH, `BAND_MID, `BAND_LOW}) else $error("bad band");
    a_enable_one: assert property (req && addr == `DEV_ENABLE_ADDR |-> wdata == 8'h01)
        else $error("bad enable");
    // enable closes the sequence: quiet port afterwards
    a_enable_last: assert property (ack && addr == `DEV_ENABLE_ADDR |=> !req [*8])
        else $error("write after enable");
endmodule : cfg_port_sva

// [tb/testbench.sv]
/* bench: controller drives the converter end over the port; table of settings.
   assumes the shared header, package and interface compiled before it. */
`include "link_cfg_defs.svh"
module testbench
    import link_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [15:0] lane, conv; logic [7:0] dec; logic [31:0] link;
        logic [2:0] err; logic [7:0] band;} row_t;
    logic        SYS_CLK = 1'b0, RST_N = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic        ARVALID = 1'b0, RREADY = 1'b0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [5:0]  AWADDR = 6'h00, ARADDR = 6'h00;
    logic [31:0] WDATA = 32'h0, RDATA, rd;
    logic [1:0]  BRESP, RRESP, resp;
    logic [15:0] conv = 16'h0, out_rate, lane_rate;
    logic [7:0]  band;
    logic        legal, active;
    int          bad_count = 0, comparisons = 0, n;
    // good settings first, then one fault of each kind
    row_t rows [8] = '{'{16'h2710, 16'h03E8, 8'h1, 32'h08200111, 3'h0, 8'h00},
        '{16'h3A98, 16'h05DC, 8'h1, 32'h08200111, 3'h0, 8'h30},
        '{16'h1194, 16'h0384, 8'h3, 32'h4C200311, 3'h0, 8'h10},
        '{16'h0BB8, 16'h0258, 8'h3, 32'h4C200311, 3'h0, 8'h50},
        '{16'h0BB8, 16'h012C, 8'h1, 32'h08200111, 3'h0, 8'h50},
        '{16'h4E20, 16'h07D0, 8'h1, 32'h08200111, 3'h1, 8'h00},
        '{16'h0BB8, 16'h03E8, 8'h1, 32'h08200111, 3'h2, 8'h00},
        '{16'h07D0, 16'h0578, 8'h7, 32'h08200111, 3'h4, 8'h00}};
    cfg_port_if u_cfg_port_if ();
    link_cfg_host u_link_cfg_host (.SYS_CLK, .RST_N, .CFG(u_cfg_port_if), .AWADDR, .AWVALID,
        .AWREADY, .WDATA, .WSTRB(4'hF), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
        .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
    link_cfg_device u_link_cfg_device (.SYS_CLK, .RST_N, .CFG(u_cfg_port_if),
        .CONV_RATE_MSPS(conv), .OUT_RATE_MSPS(out_rate), .LANE_RATE_MBPS(lane_rate),
        .BAND(band), .CFG_LEGAL(legal), .LINK_ACTIVE(active));
    cfg_port_sva u_cfg_port_sva (.SYS_CLK, .RST_N, .req(u_cfg_port_if.req),
        .wr(u_cfg_port_if.wr), .addr(u_cfg_port_if.addr), .wdata(u_cfg_port_if.wdata),
        .ack(u_cfg_port_if.ack), .rdata(u_cfg_port_if.rdata));
    always #50 SYS_CLK = ~SYS_CLK;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    // every open-ended wait goes through here so a hang ends the run
    task automatic tick(inout int k);
        @(posedge SYS_CLK);
        if (++k > 300)
        begin
            bad_count++;
            wrap_up();
        end
    endtask : tick
    task automatic axw(input logic [5:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge SYS_CLK);
        {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, d, 3'b111};
        do
        begin
            tick(k);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end
        while (!BVALID);
        resp = BRESP;
        BREADY <= 1'b0;
    endtask : axw
    task automatic axr(input logic [5:0] a);
        int k = 0;
        @(posedge SYS_CLK);
        {ARADDR, ARVALID, RREADY} <= {a, 2'b11};
        do
        begin
            tick(k);
            if (ARREADY) ARVALID <= 1'b0;
        end
        while (!RVALID);
        {rd, resp} = {RDATA, RRESP};
        RREADY <= 1'b0;
    endtask : axr
    initial
    begin
        repeat (3) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        foreach (rows[i])
        begin
            conv <= rows[i].conv;
            axw(`REG_LANE_RATE, {16'h0, rows[i].lane});
            axw(`REG_CONV_RATE, {16'h0, rows[i].conv});
            axw(`REG_DECIM, {24'h0, rows[i].dec});
            axw(`REG_LINK, rows[i].link);
            axw(`REG_CTRL, 32'h1);
            n = 0;
            do
            begin
                axr(`REG_STATUS);
                tick(n);
            end
            while (rd[`ST_DONE_BIT] !== 1'b1);
            repeat (3) @(posedge SYS_CLK); // settled outputs trail the enable write
            chk("errors", rd[4:2], rows[i].err);
            if (rows[i].err == 3'h0)
            begin
                chk("band", {rd[15:8], band}, {2{rows[i].band}});
                chk("out rate", out_rate, rows[i].conv / rows[i].dec);
                chk("lane rate", lane_rate, rows[i].lane);
                chk("legal", {legal, active}, 2'b11);
            end
        end
        // unmapped place on both paths
        axw(6'h18, 32'hFFFFFFFF);
        chk("bad write", resp, `AXI_SLVERR);
        axr(6'h18);
        chk("bad read", rd, 32'h0);
        chk("bad read resp", resp, `AXI_SLVERR);
        // second reset in mid-run drops band and link
        RST_N <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        chk("reset", {band, legal, active}, 10'h0);
        wrap_up();
    end
endmodule : testbench
